// ==== hw/uepc_regs.svh ====
// register map, field positions and reset values of the endpoint control block
`ifndef UEPC_REGS_SVH
`define UEPC_REGS_SVH

// printed offsets are register indices; byte address is four times the index
`define UEPC_EP1_IDX 8'h54
`define UEPC_EP2_IDX 8'h55
`define UEPC_EP3_IDX 8'h56
`define UEPC_EP4_IDX 8'h57
`define UEPC_EP5_IDX 8'h58
`define UEPC_EP6_IDX 8'h59
`define UEPC_EP7_IDX 8'h5A
`define UEPC_EP8_IDX 8'h5B
`define UEPC_STAT_IDX 8'h60
`define UEPC_MASK_IDX 8'h61

`define UEPC_NUM_EP 8
`define UEPC_STALL_BIT 7
`define UEPC_RSVD_BIT 6
`define UEPC_NAKIE_BIT 5
`define UEPC_ACKED_BIT 4
`define UEPC_MODE_MSB 3
`define UEPC_MODE_LSB 0

`define UEPC_CTRL_RST 8'h00
`define UEPC_MODE_RST 4'h0
`define UEPC_STAT_RST 8'h00
`define UEPC_MASK_RST 8'h00

`define UEPC_RESP_OKAY 2'h0
`define UEPC_RESP_SLVERR 2'h2

`endif

// ==== hw/uepc_pkg.sv ====
// types shared by the endpoint control block
package uepc_pkg;

  typedef enum logic [3:0] {
    MODE_DISABLED   = 4'b0000,
    MODE_NAK_IN_OUT = 4'b0001,
    MODE_ACK_OUT    = 4'b0010,
    MODE_NAK_OUT    = 4'b0011,
    MODE_ACK_IN     = 4'b0100,
    MODE_NAK_IN     = 4'b0101
  } uepc_mode_t;

  typedef enum logic [1:0] {
    HS_NONE  = 2'b00,
    HS_ACK   = 2'b01,
    HS_NAK   = 2'b10,
    HS_STALL = 2'b11
  } uepc_hs_t;

  typedef struct packed {
    logic ep_hit;
    logic [2:0] ep;
    logic stat_hit;
    logic mask_hit;
  } uepc_dec_t;

endpackage : uepc_pkg

// ==== hw/uepc_if.sv ====
// link between the register file and the response decision logic
`timescale 1ns/100ps
interface uepc_if
  import uepc_pkg::*;
  ();
  logic tok_is_in;
  logic [3:0] tok_mode;
  logic tok_stall;
  uepc_hs_t hs;
  logic [3:0] done_mode;
  logic [3:0] done_mode_nxt;

  modport regs (
    output tok_is_in,
    output tok_mode,
    output tok_stall,
    output done_mode,
    input hs,
    input done_mode_nxt
  );

  modport resp (
    input tok_is_in,
    input tok_mode,
    input tok_stall,
    input done_mode,
    output hs,
    output done_mode_nxt
  );
endinterface : uepc_if

// ==== hw/uepc_resp.sv ====
// handshake choice for a token and mode advance after an acknowledged transaction
`timescale 1ns/100ps
module uepc_resp
  import uepc_pkg::*;
  (
  uepc_if.resp bus
);

  always_comb
  begin
    bus.hs = HS_NONE;
    case (bus.tok_mode)
      MODE_NAK_IN_OUT:
        bus.hs = HS_NAK;
      MODE_ACK_OUT:
        if (!bus.tok_is_in)
        begin
          bus.hs = bus.tok_stall ? HS_STALL : HS_ACK;
        end
      MODE_NAK_OUT:
        if (!bus.tok_is_in)
        begin
          bus.hs = HS_NAK;
        end
      MODE_ACK_IN:
        if (bus.tok_is_in)
        begin
          bus.hs = bus.tok_stall ? HS_STALL : HS_ACK;
        end
      MODE_NAK_IN:
        if (bus.tok_is_in)
        begin
          bus.hs = HS_NAK;
        end
      default:
        bus.hs = HS_NONE;
    endcase
  end

  // after an acked transfer the endpoint falls back to nak so firmware can refill it
  always_comb
  begin
    bus.done_mode_nxt = bus.done_mode;
    case (bus.done_mode)
      MODE_ACK_OUT:
        bus.done_mode_nxt = MODE_NAK_OUT;
      MODE_ACK_IN:
        bus.done_mode_nxt = MODE_NAK_IN;
      default:
        bus.done_mode_nxt = bus.done_mode;
    endcase
  end

endmodule : uepc_resp

// ==== hw/uepc_top.sv ====
// endpoint control registers with axi4-lite access, handshake choice and interrupt
// Functional notes
// - stall set in ack-out mode: out packets get a stall handshake
// - stall set in ack-in mode: in tokens get a stall handshake
// - nak interrupt enable adds endpoint interrupts for nak-completed transfers
// - ack-completed transaction sets that endpoint's acked flag
// - four-bit mode steers responses and advances after acknowledged transactions
// - eight 8-bit endpoint control registers, all fields reset to zero
`timescale 1ns/100ps
`include "uepc_regs.svh"
module uepc_top
  import uepc_pkg::*;
  #(
  parameter int ADDR_W = 12
) (
  input wire logic clk,
  input wire logic rstn,
  input wire logic [ADDR_W-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [ADDR_W-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic tok_valid,
  input wire logic [2:0] tok_ep,
  input wire logic tok_is_in,
  output logic hs_valid,
  output logic [2:0] hs_ep,
  output logic [1:0] hs_code,
  input wire logic done_valid,
  input wire logic [2:0] done_ep,
  input wire logic done_ack,
  output logic ep_irq
);

  localparam int WORD_W = ADDR_W - 2;
  localparam int NEP = `UEPC_NUM_EP;

  function automatic uepc_dec_t uepc_decode(input logic [ADDR_W-1:0] a);
    logic [WORD_W-1:0] w;
    uepc_dec_t d;
    w = a[ADDR_W-1:2];
    d.ep_hit = (w >= WORD_W'(`UEPC_EP1_IDX)) && (w <= WORD_W'(`UEPC_EP8_IDX));
    d.ep = 3'(w - WORD_W'(`UEPC_EP1_IDX));
    d.stat_hit = (w == WORD_W'(`UEPC_STAT_IDX));
    d.mask_hit = (w == WORD_W'(`UEPC_MASK_IDX));
    return d;
  endfunction : uepc_decode

  // endpoint fields; bit 6 is not stored and reads zero
  logic [NEP-1:0] stall_r;
  logic [NEP-1:0] nakie_r;
  logic [NEP-1:0] acked_r;
  logic [3:0] mode_r [NEP];
  logic [NEP-1:0] stall_nxt;
  logic [NEP-1:0] nakie_nxt;
  logic [NEP-1:0] acked_nxt;
  logic [3:0] mode_nxt [NEP];
  logic [NEP-1:0] stat_r;
  logic [NEP-1:0] mask_r;
  logic [NEP-1:0] stat_nxt;
  logic [NEP-1:0] mask_nxt;
  logic irq_r;

  // bus side state
  logic awready_r;
  logic wready_r;
  logic aw_hold_r;
  logic w_hold_r;
  logic [ADDR_W-1:0] aw_addr_r;
  logic [31:0] w_data_r;
  logic [3:0] w_strb_r;
  logic bvalid_r;
  logic [1:0] bresp_r;
  logic arready_r;
  logic rvalid_r;
  logic [31:0] rdata_r;
  logic [1:0] rresp_r;

  logic hs_valid_r;
  logic [2:0] hs_ep_r;
  logic [1:0] hs_code_r;

  uepc_if eif ();

  uepc_resp u_resp (
    .bus(eif.resp)
  );

  assign eif.tok_is_in = tok_is_in;
  assign eif.tok_mode = mode_r[tok_ep];
  assign eif.tok_stall = stall_r[tok_ep];
  assign eif.done_mode = mode_r[done_ep];

  // decode and strobes
  wire aw_take = s_axi_awvalid && awready_r;
  wire w_take = s_axi_wvalid && wready_r;
  wire ar_take = s_axi_arvalid && arready_r;
  wire do_write = aw_hold_r && w_hold_r && !bvalid_r;
  wire uepc_dec_t wdec = uepc_decode(aw_addr_r);
  wire uepc_dec_t rdec = uepc_decode(s_axi_araddr);
  wire w_mapped = wdec.ep_hit || wdec.stat_hit || wdec.mask_hit;
  wire r_mapped = rdec.ep_hit || rdec.stat_hit || rdec.mask_hit;
  // only the low byte lane carries register data
  wire w_lane = do_write && w_strb_r[0];
  wire ep_wr = w_lane && wdec.ep_hit;
  wire stat_wr = w_lane && wdec.stat_hit;
  wire mask_wr = w_lane && wdec.mask_hit;
  wire rd_clr = ar_take && rdec.ep_hit;
  wire [7:0] wbyte = w_data_r[7:0];
  wire done_acked = done_valid && done_ack;
  wire [7:0] ep_rbyte = {stall_r[rdec.ep], 1'b0, nakie_r[rdec.ep], acked_r[rdec.ep],
    mode_r[rdec.ep]};
  wire [7:0] rbyte = rdec.ep_hit ? ep_rbyte :
    rdec.stat_hit ? stat_r :
    rdec.mask_hit ? mask_r : 8'h00;
  wire [1:0] rresp_nxt = r_mapped ? `UEPC_RESP_OKAY : `UEPC_RESP_SLVERR;
  wire [1:0] bresp_nxt = w_mapped ? `UEPC_RESP_OKAY : `UEPC_RESP_SLVERR;

  always_comb
  begin
    for (int i = 0; i < NEP; i++)
    begin
      stall_nxt[i] = stall_r[i];
      nakie_nxt[i] = nakie_r[i];
      mode_nxt[i] = mode_r[i];
      // firmware write wins over the engine's mode advance in the same cycle
      if (ep_wr && wdec.ep == 3'(i))
      begin
        stall_nxt[i] = wbyte[`UEPC_STALL_BIT];
        nakie_nxt[i] = wbyte[`UEPC_NAKIE_BIT];
        mode_nxt[i] = wbyte[`UEPC_MODE_MSB:`UEPC_MODE_LSB];
      end
      else if (done_acked && done_ep == 3'(i))
      begin
        mode_nxt[i] = eif.done_mode_nxt;
      end
      // acked flag is read-to-clear only; bus writes cannot touch it
      acked_nxt[i] = (done_acked && done_ep == 3'(i)) ||
        (acked_r[i] && !(rd_clr && rdec.ep == 3'(i)));
      // endpoint event: ack completion, or nak completion when enabled
      stat_nxt[i] = (done_valid && done_ep == 3'(i) && (done_ack || nakie_r[i])) ||
        (stat_r[i] && !(stat_wr && wbyte[i]));
      mask_nxt[i] = mask_wr ? wbyte[i] : mask_r[i];
    end
  end

  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      stall_r <= `UEPC_CTRL_RST;
      nakie_r <= `UEPC_CTRL_RST;
      acked_r <= `UEPC_CTRL_RST;
      stat_r <= `UEPC_STAT_RST;
      mask_r <= `UEPC_MASK_RST;
      irq_r <= 1'b0;
    end
    else
    begin
      stall_r <= stall_nxt;
      nakie_r <= nakie_nxt;
      acked_r <= acked_nxt;
      stat_r <= stat_nxt;
      mask_r <= mask_nxt;
      irq_r <= |(stat_nxt & mask_nxt);
    end
  end

  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      for (int i = 0; i < NEP; i++)
      begin
        mode_r[i] <= `UEPC_MODE_RST;
      end
    end
    else
    begin
      mode_r <= mode_nxt;
    end
  end

  // one handshake per token whose mode answers it, one cycle after it; HS_NONE raises no hs_valid
  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      hs_valid_r <= 1'b0;
      hs_ep_r <= 3'h0;
      hs_code_r <= HS_NONE;
    end
    else
    begin
      hs_valid_r <= tok_valid && (eif.hs != HS_NONE);
      hs_ep_r <= tok_ep;
      hs_code_r <= eif.hs;
    end
  end

  // write address and data are taken independently and held until the write
  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      awready_r <= 1'b1;
      aw_hold_r <= 1'b0;
      aw_addr_r <= '0;
    end
    else if (aw_take)
    begin
      awready_r <= 1'b0;
      aw_hold_r <= 1'b1;
      aw_addr_r <= s_axi_awaddr;
    end
    else
    begin
      aw_hold_r <= aw_hold_r && !do_write;
      awready_r <= awready_r || (bvalid_r && s_axi_bready);
    end
  end

  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      wready_r <= 1'b1;
      w_hold_r <= 1'b0;
      w_data_r <= 32'h0;
      w_strb_r <= 4'h0;
    end
    else if (w_take)
    begin
      wready_r <= 1'b0;
      w_hold_r <= 1'b1;
      w_data_r <= s_axi_wdata;
      w_strb_r <= s_axi_wstrb;
    end
    else
    begin
      w_hold_r <= w_hold_r && !do_write;
      wready_r <= wready_r || (bvalid_r && s_axi_bready);
    end
  end

  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      bvalid_r <= 1'b0;
      bresp_r <= `UEPC_RESP_OKAY;
    end
    else if (do_write)
    begin
      bvalid_r <= 1'b1;
      bresp_r <= bresp_nxt;
    end
    else if (s_axi_bready)
    begin
      bvalid_r <= 1'b0;
    end
  end

  // reads answer one cycle after the address is taken; the clear acts at that edge
  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      arready_r <= 1'b1;
      rvalid_r <= 1'b0;
      rdata_r <= 32'h0;
      rresp_r <= `UEPC_RESP_OKAY;
    end
    else if (ar_take)
    begin
      arready_r <= 1'b0;
      rvalid_r <= 1'b1;
      rdata_r <= {24'h0, rbyte};
      rresp_r <= rresp_nxt;
    end
    else if (rvalid_r && s_axi_rready)
    begin
      arready_r <= 1'b1;
      rvalid_r <= 1'b0;
    end
  end

  assign s_axi_awready = awready_r;
  assign s_axi_wready = wready_r;
  assign s_axi_bvalid = bvalid_r;
  assign s_axi_bresp = bresp_r;
  assign s_axi_arready = arready_r;
  assign s_axi_rvalid = rvalid_r;
  assign s_axi_rdata = rdata_r;
  assign s_axi_rresp = rresp_r;
  assign hs_valid = hs_valid_r;
  assign hs_ep = hs_ep_r;
  assign hs_code = hs_code_r;
  assign ep_irq = irq_r;

endmodule : uepc_top

// ==== sim/uepc_top_asserts.sv ====
// port checker for the endpoint control block
`timescale 1ns/100ps
module uepc_top_asserts
  (
  input wire logic clk,
  input wire logic rstn,
  input wire logic s_axi_awready,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [1:0] s_axi_bresp,
  input wire logic tok_valid,
  input wire logic [2:0] tok_ep,
  input wire logic hs_valid,
  input wire logic [2:0] hs_ep,
  input wire logic [1:0] hs_code,
  input wire logic done_valid,
  input wire logic ep_irq
);
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rstn);
  sequence s_ar_take;
    s_axi_arvalid && s_axi_arready;
  endsequence
  sequence s_b_wait;
    s_axi_bvalid && !s_axi_bready;
  endsequence
  property p_hs_src;
    hs_valid |-> $past(tok_valid) && hs_ep == $past(tok_ep);
  endproperty
  a_hs_src: assert property (p_hs_src) else $error("stray handshake");
  property p_hs_code;
    hs_valid |-> hs_code != 2'h0;
  endproperty
  a_hs_code: assert property (p_hs_code) else $error("empty handshake");
  property p_rd;
    s_ar_take |=> s_axi_rvalid && !s_axi_arready;
  endproperty
  a_rd: assert property (p_rd) else $error("late read");
  property p_b_hold;
    s_b_wait |=> s_axi_bvalid && $stable(s_axi_bresp);
  endproperty
  a_b_hold: assert property (p_b_hold) else $error("response dropped");
  property p_rst;
    !$past(rstn) |-> !hs_valid && !ep_irq && !s_axi_bvalid && s_axi_awready;
  endproperty
  a_rst: assert property (p_rst) else $error("bad reset state");
  // a rise needs a completion or a mask write behind it
  property p_irq;
    $rose(ep_irq) |-> $past(done_valid) || !$past(s_axi_awready);
  endproperty
  a_irq: assert property (p_irq) else $error("irq without cause");
  property p_irq_fall;
    $fell(ep_irq) |-> !$past(s_axi_awready);
  endproperty
  a_irq_fall: assert property (p_irq_fall) else $error("irq lost");
endmodule : uepc_top_asserts
bind uepc_top uepc_top_asserts u_asserts (.clk, .rstn, .s_axi_awready, .s_axi_arvalid,
  .s_axi_arready, .s_axi_rvalid, .s_axi_bvalid, .s_axi_bready, .s_axi_bresp, .tok_valid,
  .tok_ep, .hs_valid, .hs_ep, .hs_code, .done_valid, .ep_irq);

// ==== sim/uepc_host.sv ====
// host model: tokens and completions toward the engine
`timescale 1ns/100ps
module uepc_host
  (
  input wire logic clk,
  output logic tok_valid = 1'b0,
  output logic [2:0] tok_ep = 3'h0,
  output logic tok_is_in = 1'b0,
  output logic done_valid = 1'b0,
  output logic [2:0] done_ep = 3'h0,
  output logic done_ack = 1'b0
);
  // idle lines invert, so a stale value never passes for a live one
  task automatic send(input logic [2:0] ep, input logic is_in);
    @(posedge clk);
    tok_valid <= 1'b1;
    tok_ep <= ep;
    tok_is_in <= is_in;
    @(posedge clk);
    tok_valid <= 1'b0;
    tok_ep <= ~ep;
    tok_is_in <= ~is_in;
  endtask : send
  task automatic finish(input logic [2:0] ep, input logic ack);
    @(posedge clk);
    done_valid <= 1'b1;
    done_ep <= ep;
    done_ack <= ack;
    @(posedge clk);
    done_valid <= 1'b0;
    done_ep <= ~ep;
    done_ack <= ~ack;
  endtask : finish
endmodule : uepc_host

// ==== sim/usb_endpoint_control_bench.sv ====
// register and handshake bench for the endpoint control block
`timescale 1ns/100ps
`include "uepc_regs.svh"
module usb_endpoint_control_bench
  import uepc_pkg::*;
  ;
  logic clk = 1'b0;
  logic rstn = 1'b0;
  logic [11:0] s_axi_awaddr = 12'h000, s_axi_araddr = 12'h000;
  logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata;
  logic [3:0] s_axi_wstrb = 4'hF;
  logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
  logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic hs_valid, ep_irq, tok_valid, tok_is_in, done_valid, done_ack;
  logic [1:0] s_axi_bresp, s_axi_rresp, hs_code;
  logic [2:0] tok_ep, done_ep, hs_ep;
  int failures = 0;
  int check_count = 0;
  int cyc = 0;
  int i;
  always #4 clk = ~clk;
  uepc_top #(.ADDR_W(12)) dut (.clk, .rstn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
    .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
    .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
    .s_axi_rvalid, .s_axi_rready, .tok_valid, .tok_ep, .tok_is_in, .hs_valid, .hs_ep, .hs_code,
    .done_valid, .done_ep, .done_ack, .ep_irq);
  uepc_host host (.clk, .tok_valid, .tok_ep, .tok_is_in, .done_valid, .done_ep, .done_ack);
  task automatic complete_run;
    if (failures == 0 && check_count > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask : complete_run
  always @(posedge clk)
  begin
    cyc <= cyc + 1;
    if (cyc == 5000)
    begin
      failures++;
      complete_run();
    end
  end
  task automatic chk(input logic [33:0] s, input logic [33:0] e);
    check_count++;
    if (s !== e)
    begin
      failures++;
      $display("[ERR] %0t seen %0h exp %0h", $time, s, e);
    end
  endtask : chk
  task automatic wr(input logic [11:0] a, input logic [7:0] d, input logic [1:0] er = 2'h0);
    @(posedge clk);
    s_axi_awaddr <= a;
    s_axi_wdata <= {24'h0, d};
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    // bready follows bvalid by a cycle so the response must hold under backpressure
    do
    begin
      @(posedge clk);
      if (s_axi_awready)
        s_axi_awvalid <= 1'b0;
      if (s_axi_wready)
        s_axi_wvalid <= 1'b0;
      if (s_axi_bvalid && !s_axi_bready)
        s_axi_bready <= 1'b1;
    end
    while (s_axi_bvalid !== 1'b1 || s_axi_bready !== 1'b1);
    s_axi_bready <= 1'b0;
    chk(s_axi_bresp, er);
  endtask : wr
  task automatic rd(input logic [11:0] a, input logic [7:0] d, input logic [1:0] er = 2'h0);
    @(posedge clk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do
    begin
      @(posedge clk);
      if (s_axi_arready)
        s_axi_arvalid <= 1'b0;
    end
    while (s_axi_rvalid !== 1'b1);
    s_axi_rready <= 1'b0;
    chk({s_axi_rresp, s_axi_rdata}, {er, 24'h0, d});
  endtask : rd
  task automatic tk(input logic [2:0] ep, input logic is_in, input uepc_hs_t e);
    logic on;
    on = (e != HS_NONE);
    host.send(ep, is_in);
    #1;
    chk({hs_valid, hs_valid ? {hs_ep, hs_code} : 5'h00}, {on, on ? {ep, e} : 5'h00});
  endtask : tk
  task automatic dn(input logic [2:0] ep, input logic ack, input logic irq);
    host.finish(ep, ack);
    #1;
    chk(ep_irq, irq);
  endtask : dn
  function automatic uepc_hs_t ex(input int m, input logic is_in);
    case (m)
      1: ex = HS_NAK;
      2: ex = is_in ? HS_NONE : HS_ACK;
      3: ex = is_in ? HS_NONE : HS_NAK;
      4: ex = is_in ? HS_ACK : HS_NONE;
      5: ex = is_in ? HS_NAK : HS_NONE;
      default: ex = HS_NONE;
    endcase
  endfunction : ex
  initial
  begin
    repeat (2) @(posedge clk);
    rstn <= 1'b1;
    for (i = 0; i < 8; i++)
    begin
      rd(12'h150 + 12'(4 * i), 8'h00);
      wr(12'h150 + 12'(4 * i), 8'h3F);
      rd(12'h150 + 12'(4 * i), 8'h2F);
    end
    rd(12'h200, 8'h00, `UEPC_RESP_SLVERR);
    wr(12'h200, 8'h01, `UEPC_RESP_SLVERR);
    for (i = 0; i < 7; i++)
    begin
      wr(12'h16C, 8'(i));
      tk(3'h7, 1'b1, ex(i, 1'b1));
      tk(3'h7, 1'b0, ex(i, 1'b0));
    end
    wr(12'h150, 8'h82);
    rd(12'h150, 8'h82);
    tk(3'h0, 1'b0, HS_STALL);
    tk(3'h0, 1'b1, HS_NONE);
    wr(12'h154, 8'h84);
    tk(3'h1, 1'b1, HS_STALL);
    tk(3'h1, 1'b0, HS_NONE);
    // stall cleared; endpoint 1 disabled, endpoint 0 kept in ack-out mode
    wr(12'h154, 8'h00);
    wr(12'h150, 8'h02);
    tk(3'h0, 1'b0, HS_ACK);
    wr(12'h184, 8'h01);
    dn(3'h0, 1'b1, 1'b1);
    rd(12'h150, 8'h13);
    rd(12'h150, 8'h03);
    tk(3'h0, 1'b0, HS_NAK);
    rd(12'h180, 8'h01);
    wr(12'h180, 8'h01);
    chk(ep_irq, 1'b0);
    wr(12'h158, 8'h23);
    wr(12'h184, 8'h04);
    dn(3'h2, 1'b0, 1'b1);
    rd(12'h180, 8'h04);
    wr(12'h180, 8'h04);
    wr(12'h15C, 8'h03);
    wr(12'h184, 8'h08);
    dn(3'h3, 1'b0, 1'b0);
    rd(12'h15C, 8'h03);
    // a write with the low lane disabled must leave the register alone
    s_axi_wstrb <= 4'h0;
    wr(12'h15C, 8'h82);
    s_axi_wstrb <= 4'hF;
    rd(12'h15C, 8'h03);
    complete_run();
  end
endmodule : usb_endpoint_control_bench
